//--- pkg/wake_pkg.sv
// Constants shared by the wake event and power mode control block.
package wake_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] POWER_EVENT_CONTROL_OFS = 8'hD4;
	localparam logic [7:0] SLEEP_WAKE_TIME_OFS     = 8'hD6;
	localparam logic [7:0] GLOBAL_RESET_OFS        = 8'h26;
	localparam logic [7:0] INT_STATUS_OFS          = 8'h92;
	localparam logic [7:0] INT_MASK_OFS            = 8'h90;

	// ****************************************************************
	// Field positions of the power event control register
	// ****************************************************************
	localparam int DELAY_EN_BIT   = 14;
	localparam int RSVD13_BIT     = 13;
	localparam int POLARITY_BIT   = 12;
	localparam int ENABLE_LO      = 8;
	localparam int AUTO_WAKE_BIT  = 7;
	localparam int TO_NORMAL_BIT  = 6;
	localparam int EVENT_LO       = 2;
	localparam int MODE_LO        = 0;

	// Event bit order inside the indication and enable fields.
	localparam int EV_ENERGY = 0;
	localparam int EV_LINK   = 1;
	localparam int EV_REMOTE = 2;
	localparam int EV_FRAME  = 3;

	// Interrupt status bits.
	localparam int ISR_ENERGY_BIT = 2;
	localparam int ISR_LINK_BIT   = 3;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0]  WAKE_TIME_RST  = 8'h08;
	localparam logic [7:0]  SLEEP_TIME_RST = 8'h0C;
	localparam logic [15:0] ISR_RST        = 16'h0000;
	localparam logic [15:0] MASK_RST       = 16'h0000;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS   = 4;
	localparam int WAKE_UNIT_NS    = 16_000_000;
	localparam int SLEEP_UNIT_NS   = 1_000_000_000;
	localparam int WAKE_UNIT_CYC   = WAKE_UNIT_NS / CLK_PERIOD_NS;
	localparam int SLEEP_UNIT_CYC  = SLEEP_UNIT_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_ENERGY,
		MODE_SOFT_DOWN,
		MODE_SAVING
	} power_mode_e;

endpackage : wake_pkg

//--- design/sustain_timer.sv
// Timer that reports a level held without a break for a number of units.
`timescale 1ns/100ps
`default_nettype none

module sustain_timer #(
	parameter int UNIT_CYC = 4
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       run,
	input  wire logic [7:0] limit,
	output logic            done
);

	// A zero limit is not a legal setting; it is taken as one unit.
	wire logic [7:0] target = (limit == 8'h00) ? 8'h01 : limit;
	wire logic       unitEnd;
	logic [31:0]     preCnt_r;
	logic [7:0]      units_r;

	assign unitEnd = (preCnt_r == 32'(UNIT_CYC - 1));
	assign done    = run && (units_r >= target);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			preCnt_r <= 32'h0;
			units_r  <= 8'h00;
		end else if (!run) begin
			preCnt_r <= 32'h0;
			units_r  <= 8'h00;
		end else if (unitEnd) begin
			preCnt_r <= 32'h0;
			if (units_r != 8'hFF)
				units_r <= units_r + 8'h01;
		end else begin
			preCnt_r <= preCnt_r + 32'h1;
		end
	end

endmodule : sustain_timer
`default_nettype wire

//--- design/wake_event_power_mode_control.sv
// Power mode selection, wake event recording and wake event output pin.
//
// Summary of operation
// - Delay bit holds output until clocks ready.
// - Delay clear asserts at once; needs auto wake.
// - Polarity bit picks high or low active.
// - Per-event enables gate the output.
// - Auto wake leaves low power after energy.
// - Normal power state allows receive and transmit.
// - Wake-to-normal bit also returns mode to normal.
// - Indication field codes the wake cause.
// - Energy and link wakes set status bits.
// - Indicated enabled event asserts the output.
// - Indications clear by power-up or one-write.
// - Cleared indications deassert the output.
// - Two-bit field selects four power modes.
// - Energy mode has low and normal states.
// - Energy or reset register read wakes.
// - Soft power down wakes by register read only.
// - Energy held for wake time, sixteen ms units.
// - No energy for sleep time, one second units.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module wake_event_power_mode_control #(
	parameter int WAKE_CYC  = wake_pkg::WAKE_UNIT_CYC,
	parameter int SLEEP_CYC = wake_pkg::SLEEP_UNIT_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        swReset,
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdData,
	input  wire logic        energyPin,
	input  wire logic        linkUpPin,
	input  wire logic        wakeFrameRx,
	input  wire logic        remoteWakeRx,
	input  wire logic        clocksReady,
	output logic             wakeEventOut,
	output logic      [1:0]  powerMode,
	output logic             lowPowerState,
	output logic             rxTxEnable,
	output logic             irq
);
	import wake_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic energyMeta_r, energy_r, linkMeta_r, link_r, linkLast_r;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			energyMeta_r <= 1'b0;
			energy_r     <= 1'b0;
			linkMeta_r   <= 1'b0;
			link_r       <= 1'b0;
			linkLast_r   <= 1'b0;
		end else begin
			energyMeta_r <= energyPin;
			energy_r     <= energyMeta_r;
			linkMeta_r   <= linkUpPin;
			link_r       <= linkMeta_r;
			linkLast_r   <= link_r;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic        delayEn_r, rsvd13_r, polarity_r, autoWake_r, toNormal_r;
	logic [3:0]  enables_r, events_r, events_nxt;
	logic [1:0]  mode_r, mode_nxt;
	logic        lowPower_r, lowPower_nxt;
	logic [7:0]  wakeTime_r, sleepTime_r;
	logic [15:0] isr_r, isr_nxt, mask_r;
	logic        asserted_r;

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire logic wrPec   = regWr && (regAddr == POWER_EVENT_CONTROL_OFS);
	wire logic wrTime  = regWr && (regAddr == SLEEP_WAKE_TIME_OFS);
	wire logic wrMask  = regWr && (regAddr == INT_MASK_OFS);
	wire logic rdIsr   = regRd && (regAddr == INT_STATUS_OFS);
	wire logic rdGrr   = regRd && (regAddr == GLOBAL_RESET_OFS);
	wire logic inEnergy  = (mode_r == MODE_ENERGY);
	wire logic inSoftDwn = (mode_r == MODE_SOFT_DOWN);
	wire logic sleepDone, wakeDone;

	// Only the low power state of energy mode runs the wake timer.
	sustain_timer #(.UNIT_CYC(WAKE_CYC)) wakeTimer (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.run     (inEnergy && lowPower_r && autoWake_r && energy_r),
		.limit   (wakeTime_r),
		.done    (wakeDone)
	);

	sustain_timer #(.UNIT_CYC(SLEEP_CYC)) sleepTimer (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.run     (inEnergy && !lowPower_r && !energy_r),
		.limit   (sleepTime_r),
		.done    (sleepDone)
	);

	wire logic energyWake = wakeDone && inEnergy && lowPower_r
		&& autoWake_r;
	wire logic hostWake = rdGrr && ((inEnergy && lowPower_r)
		|| inSoftDwn);
	wire logic linkRise = link_r && !linkLast_r
		&& (mode_r != MODE_NORMAL);
	wire logic frameEv  = wakeFrameRx && (mode_r != MODE_NORMAL);
	wire logic remoteEv = remoteWakeRx && (mode_r != MODE_NORMAL);

	wire logic [3:0] evSet = {frameEv, remoteEv, linkRise,
		energyWake};
	wire logic [3:0] evClr = wrPec ? regWrData[EVENT_LO +: 4] : 4'h0;
	wire logic [15:0] isrSet = 16'(
		({15'h0, energyWake} << ISR_ENERGY_BIT)
		| ({15'h0, linkRise} << ISR_LINK_BIT));

	wire logic pending = |(events_r & enables_r);
	wire logic holdOff = delayEn_r && autoWake_r
		&& !clocksReady;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		// Set wins over a one-write in the same cycle.
		events_nxt = (events_r & ~evClr) | evSet;
		isr_nxt    = (rdIsr ? 16'h0000 : isr_r) | isrSet;
		mode_nxt   = wrPec ? regWrData[MODE_LO +: 2] : mode_r;
		lowPower_nxt = lowPower_r;
		if (inEnergy && !lowPower_r && sleepDone)
			lowPower_nxt = 1'b1;
		if (energyWake) begin
			lowPower_nxt = 1'b0;
			if (toNormal_r)
				mode_nxt = MODE_NORMAL;
		end
		if (hostWake) begin
			lowPower_nxt = 1'b0;
			mode_nxt     = MODE_NORMAL;
		end
		if (mode_nxt != MODE_ENERGY)
			lowPower_nxt = 1'b0;
	end

	// Wake indications survive the soft reset; only rst_b or a one-write clears them.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			events_r <= 4'h0;
			isr_r    <= ISR_RST;
		end else begin
			events_r <= events_nxt;
			isr_r    <= isr_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			delayEn_r  <= 1'b0;
			rsvd13_r   <= 1'b0;
			polarity_r <= 1'b0;
			enables_r  <= 4'h0;
			autoWake_r <= 1'b0;
			toNormal_r <= 1'b0;
		end else if (swReset) begin
			delayEn_r  <= 1'b0;
			rsvd13_r   <= 1'b0;
			polarity_r <= 1'b0;
			enables_r  <= 4'h0;
			autoWake_r <= 1'b0;
			toNormal_r <= 1'b0;
		end else if (wrPec) begin
			delayEn_r  <= regWrData[DELAY_EN_BIT];
			rsvd13_r   <= regWrData[RSVD13_BIT];
			polarity_r <= regWrData[POLARITY_BIT];
			enables_r  <= regWrData[ENABLE_LO +: 4];
			autoWake_r <= regWrData[AUTO_WAKE_BIT];
			toNormal_r <= regWrData[TO_NORMAL_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mode_r      <= MODE_NORMAL;
			lowPower_r  <= 1'b0;
			wakeTime_r  <= WAKE_TIME_RST;
			sleepTime_r <= SLEEP_TIME_RST;
			mask_r      <= MASK_RST;
		end else if (swReset) begin
			mode_r      <= MODE_NORMAL;
			lowPower_r  <= 1'b0;
			wakeTime_r  <= WAKE_TIME_RST;
			sleepTime_r <= SLEEP_TIME_RST;
			mask_r      <= MASK_RST;
		end else begin
			mode_r     <= mode_nxt;
			lowPower_r <= lowPower_nxt;
			if (wrTime) begin
				wakeTime_r  <= regWrData[15:8];
				sleepTime_r <= regWrData[7:0];
			end
			if (wrMask)
				mask_r <= regWrData;
		end
	end

	// ****************************************************************
	// Wake event pin
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			asserted_r   <= 1'b0;
			wakeEventOut <= 1'b1;
		end else begin
			asserted_r   <= pending && !holdOff;
			wakeEventOut <= (pending && !holdOff) ~^ polarity_r;
		end
	end

	// ****************************************************************
	// Read data and status outputs
	// ****************************************************************
	wire logic [15:0] pecView = {1'b0, delayEn_r, rsvd13_r, polarity_r,
		enables_r, autoWake_r, toNormal_r, events_r,
		mode_r};
	wire logic [15:0] rdMux =
		(regAddr == POWER_EVENT_CONTROL_OFS) ? pecView :
		(regAddr == SLEEP_WAKE_TIME_OFS) ? {wakeTime_r, sleepTime_r} :
		(regAddr == INT_STATUS_OFS) ? isr_r :
		(regAddr == INT_MASK_OFS) ? mask_r : 16'h0000;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			regRdData <= 16'h0000;
		else
			regRdData <= regRd ? rdMux : 16'h0000;
	end

	assign powerMode     = mode_r;
	assign lowPowerState = lowPower_r;
	// Saving the whole datapath is traded for a slow wake from low power.
	assign rxTxEnable = (mode_r == MODE_NORMAL)
		|| (inEnergy && !lowPower_r);
	assign irq = |(isr_r & mask_r);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_delay_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		holdOff |=> !asserted_r)
		else $error("wake output asserted before clocks ready");

	a_no_delay: assert property (@(posedge clk_sys) disable iff (!rst_b)
		pending && !(delayEn_r && autoWake_r) |=> asserted_r)
		else $error("wake output late without delay");

	a_pin_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
		##1 wakeEventOut == ($past(polarity_r) ? asserted_r : !asserted_r))
		else $error("wake pin level does not follow polarity");

	a_enable_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(events_r & enables_r) == 4'h0 |=> !asserted_r)
		else $error("wake output without enabled event");

	a_energy_wake: assert property (@(posedge clk_sys) disable iff (!rst_b)
		energyWake && !wrPec && !swReset |=> !lowPower_r && events_r[EV_ENERGY]
		&& isr_r[ISR_ENERGY_BIT])
		else $error("energy wake not taken");

	a_to_normal: assert property (@(posedge clk_sys) disable iff (!rst_b)
		energyWake && !toNormal_r && !wrPec && !rdGrr && !swReset
		|=> mode_r == MODE_ENERGY)
		else $error("mode left energy detect without wake-to-normal");

	a_event_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!wrPec |=> (events_r & $past(events_r)) == $past(events_r))
		else $error("wake indication lost without one-write");

	a_soft_down: assert property (@(posedge clk_sys) disable iff (!rst_b)
		inSoftDwn && !rdGrr && !wrPec && !swReset |=> mode_r == MODE_SOFT_DOWN)
		else $error("soft power down left without host wake");

	a_host_wake: assert property (@(posedge clk_sys) disable iff (!rst_b)
		hostWake && !swReset |=> mode_r == MODE_NORMAL && rxTxEnable)
		else $error("host read did not wake device");

endmodule : wake_event_power_mode_control
`default_nettype wire

//--- testbench/line_partner.sv
// Model of the line side and system wake logic that feed the block.
`timescale 1ns/100ps
`default_nettype none

module line_partner (
	input  wire logic clk_sys,
	output var logic  energyPin,
	output var logic  linkUpPin,
	output var logic  wakeFrameRx,
	output var logic  remoteWakeRx,
	output var logic  clocksReady
);
	initial begin
		energyPin = 1'b0;
		linkUpPin = 1'b0;
		wakeFrameRx = 1'b0;
		remoteWakeRx = 1'b0;
		clocksReady = 1'b1;
	end

	// Receive strobes are single-cycle pulses on the system clock.
	task automatic frame();
		@(posedge clk_sys) wakeFrameRx <= 1'b1;
		@(posedge clk_sys) wakeFrameRx <= 1'b0;
	endtask : frame

	task automatic remote();
		@(posedge clk_sys) remoteWakeRx <= 1'b1;
		@(posedge clk_sys) remoteWakeRx <= 1'b0;
	endtask : remote

	task automatic level(input int sel, input logic v);
		@(posedge clk_sys);
		if (sel == 0) energyPin <= v;
		else if (sel == 1) linkUpPin <= v;
		else clocksReady <= v;
	endtask : level
endmodule : line_partner
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the wake event and power mode block.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import wake_pkg::*;
	logic        clk_sys, rst_b, swReset, regWr, regRd;
	logic [7:0]  regAddr;
	logic [15:0] regWrData, regRdData, d, ev;
	logic        energyPin, linkUpPin, wakeFrameRx, remoteWakeRx;
	logic        clocksReady, wakeEventOut, lowPowerState, rxTxEnable, irq;
	logic [1:0]  powerMode;
	int          errors = 0;
	int          comparisons = 0;

	wake_event_power_mode_control #(.WAKE_CYC(4), .SLEEP_CYC(8)) dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .swReset(swReset),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .energyPin(energyPin),
		.linkUpPin(linkUpPin), .wakeFrameRx(wakeFrameRx),
		.remoteWakeRx(remoteWakeRx), .clocksReady(clocksReady),
		.wakeEventOut(wakeEventOut), .powerMode(powerMode),
		.lowPowerState(lowPowerState), .rxTxEnable(rxTxEnable), .irq(irq));
	line_partner p (.clk_sys(clk_sys), .energyPin(energyPin),
		.linkUpPin(linkUpPin), .wakeFrameRx(wakeFrameRx),
		.remoteWakeRx(remoteWakeRx), .clocksReady(clocksReady));

	// ****************************************************************
	// Bus tasks and checks
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge clk_sys) regWr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys) regRd <= 1'b0;
		#1 v = regRdData;
	endtask : rd

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// A hung handshake would otherwise stall the run for good.
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		stop_test();
	end

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		{rst_b, swReset, regWr, regRd, regAddr, regWrData} = '0;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(POWER_EVENT_CONTROL_OFS, d); chk(d, 16'h0000);
		cyc(1);
		chk(regRdData, 16'h0000);
		rd(SLEEP_WAKE_TIME_OFS, d); chk(d, 16'h080C);
		chk(rxTxEnable, 16'h1);
		wr(POWER_EVENT_CONTROL_OFS, 16'hFFFF);
		rd(POWER_EVENT_CONTROL_OFS, d); chk(d, 16'h7FC3);
		for (int m = 0; m < 4; m++) begin
			wr(POWER_EVENT_CONTROL_OFS, 16'(m));
			chk(powerMode, 16'(m));
		end
		rd(8'h00, d); chk(d, 16'h0000);
		wr(INT_MASK_OFS, 16'h0008);
		for (int i = 0; i < 3; i++) begin
			ev = 16'h0020 >> i;
			wr(POWER_EVENT_CONTROL_OFS, 16'h1F03);
			if (i == 0) p.frame();
			else if (i == 1) p.remote();
			else p.level(1, 1'b1);
			cyc(6);
			chk(irq, 16'(i == 2));
			rd(INT_STATUS_OFS, d); chk(d, (i == 2) ? 16'h0008 : 16'h0);
			chk(irq, 16'h0);
			rd(POWER_EVENT_CONTROL_OFS, d); chk(d, 16'h1F03 | ev);
			chk(wakeEventOut, 16'h1);
			wr(POWER_EVENT_CONTROL_OFS, 16'h1F03 | ev);
			cyc(3);
			chk(wakeEventOut, 16'h0);
		end
		wr(POWER_EVENT_CONTROL_OFS, 16'h0703);
		p.frame();
		cyc(6);
		chk(wakeEventOut, 16'h1);
		p.remote();
		cyc(6);
		chk(wakeEventOut, 16'h0);
		@(posedge clk_sys) swReset <= 1'b1;
		@(posedge clk_sys) swReset <= 1'b0;
		rd(POWER_EVENT_CONTROL_OFS, d); chk(d, 16'h0030);
		wr(POWER_EVENT_CONTROL_OFS, 16'h0030);
		rd(POWER_EVENT_CONTROL_OFS, d); chk(d, 16'h0000);
		p.level(2, 1'b0);
		wr(POWER_EVENT_CONTROL_OFS, 16'h5F83);
		p.frame();
		cyc(8);
		chk(wakeEventOut, 16'h0);
		p.level(2, 1'b1);
		cyc(3);
		chk(wakeEventOut, 16'h1);
		wr(POWER_EVENT_CONTROL_OFS, 16'h5FA3);
		wr(POWER_EVENT_CONTROL_OFS, 16'h11C1);
		cyc(120);
		chk(lowPowerState, 16'h1);
		chk(rxTxEnable, 16'h0);
		p.level(0, 1'b1);
		cyc(20);
		chk(lowPowerState, 16'h1);
		cyc(30);
		chk(lowPowerState, 16'h0);
		chk(powerMode, 16'h0);
		rd(POWER_EVENT_CONTROL_OFS, d); chk(d, 16'h11C4);
		chk(wakeEventOut, 16'h1);
		rd(INT_STATUS_OFS, d); chk(d, 16'h0004);
		wr(POWER_EVENT_CONTROL_OFS, 16'h0006);
		cyc(60);
		chk(powerMode, 16'h2);
		rd(GLOBAL_RESET_OFS, d); chk(d, 16'h0000);
		cyc(1);
		chk(powerMode, 16'h0);
		// Energy wake with wake-to-normal clear stays in energy detect.
		p.level(0, 1'b0);
		wr(POWER_EVENT_CONTROL_OFS, 16'h0081);
		cyc(120);
		chk(lowPowerState, 16'h1);
		p.level(0, 1'b1);
		cyc(50);
		chk(lowPowerState, 16'h0);
		chk(powerMode, 16'h1);
		chk(rxTxEnable, 16'h1);
		// A host read of the reset register wakes the low power state.
		p.level(0, 1'b0);
		cyc(120);
		chk(lowPowerState, 16'h1);
		rd(GLOBAL_RESET_OFS, d); chk(d, 16'h0000);
		chk(powerMode, 16'h0);
		chk(lowPowerState, 16'h0);
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
